// File: scg_pkg.sv
// Constants, field layouts and helper functions for the system clock generation unit.
`default_nettype none
package scg_pkg;
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned NUM_BUS_OUT = 5;
	localparam int unsigned NUM_UNITS = 7;
	localparam int unsigned NUM_LCLK = 3;
	localparam int unsigned CPU_SEL_W = 7;
	localparam logic [4:0] OFF_OUTPUT_CLOCK_CONTROL = 5'h00;
	localparam logic [4:0] OFF_SYSTEM_CLOCK_CONTROL = 5'h04;
	localparam logic [4:0] OFF_LOCAL_BUS_RATIO = 5'h08;
	localparam logic [4:0] OFF_RESET_CONFIG_WORD_LOW = 5'h0C;
	localparam logic [4:0] OFF_CLOCK_STATUS = 5'h10;
	localparam logic [1:0] UCM_OFF = 2'h0;
	localparam logic [1:0] UCM_FULL = 2'h1;
	localparam logic [1:0] UCM_HALF = 2'h2;
	localparam logic [1:0] UCM_THIRD = 2'h3;
	localparam logic [1:0] UCM_RESET = UCM_THIRD;
	localparam logic [1:0] LBDIV_2 = 2'h0;
	localparam logic [1:0] LBDIV_4 = 2'h1;
	localparam logic [1:0] LBDIV_8 = 2'h2;
	localparam logic [1:0] LBDIV_RESET = LBDIV_8;
	localparam logic [4:0] OCC_RESET = 5'h1F;
	localparam logic [2:0] LOCK_EDGES = 3'h4;
	localparam logic [31:0] RCW_HARD_CODED = 32'h0402_0000;
	localparam logic [31:0] RCW_RESET = 32'h0000_0000;

	typedef struct packed {
		logic local_bus_clock_mode;
		logic memory_clock_mode;
		logic [1:0] oscillator_divider_select;
		logic [3:0] system_pll_multiplier;
		logic rsv_hi;
		logic [6:0] cpu_pll_select;
		logic [15:0] rsv_lo;
	} scg_rcw_t;

	typedef struct packed {
		logic [17:0] zero;
		logic sync_locked;
		logic host_mode;
		logic reference_halve;
		logic vco_double;
		logic mult_reserved;
		logic [3:0] vco_divide;
		logic [4:0] csb_ratio;
	} scg_status_t;

	// Divide-by-four, eight, two and one for codes 00, 01, 10 and 11.
	function automatic logic [3:0] vco_divide_of(input logic [1:0] code);
		case (code)
			2'h0: vco_divide_of = 4'h4;
			2'h1: vco_divide_of = 4'h8;
			2'h2: vco_divide_of = 4'h2;
			default: vco_divide_of = 4'h1;
		endcase
	endfunction

	// Last count of a unit divider: full, half, third.
	function automatic logic [1:0] unit_last_count(input logic [1:0] mode);
		case (mode)
			UCM_HALF: unit_last_count = 2'h1;
			UCM_THIRD: unit_last_count = 2'h2;
			default: unit_last_count = 2'h0;
		endcase
	endfunction

	// Last tick count of each half period of the local bus clock.
	function automatic logic [1:0] lb_half_last(input logic [1:0] code);
		case (code)
			LBDIV_2: lb_half_last = 2'h0;
			LBDIV_4: lb_half_last = 2'h1;
			default: lb_half_last = 2'h3;
		endcase
	endfunction
endpackage
`default_nettype wire

// File: scg_system_clock_generation_unit.sv
// System clock generation unit: reference select, bus clock outputs, ratios and unit gating.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module scg_system_clock_generation_unit
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic host_mode_strap,
	input wire logic host_reference_input,
	input wire logic agent_bus_clock_input,
	input wire logic reference_halve_strap,
	input wire logic sync_return_input,
	input wire logic hard_coded_select,
	input wire logic [31:0] reset_config_word_pins,
	input wire logic [scg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic sync_clock_output,
	output logic [scg_pkg::NUM_BUS_OUT-1:0] bus_clock_outputs,
	output logic memory_bus_clock,
	output logic memory_bus_clock_n,
	output logic [scg_pkg::NUM_LCLK-1:0] local_bus_clock_outputs,
	output logic [scg_pkg::NUM_UNITS-1:0] unit_clock_enables,
	output logic [scg_pkg::CPU_SEL_W-1:0] cpu_pll_select,
	output logic [4:0] csb_ratio
);
	logic [1:0] host_ref_s_q;
	logic [1:0] bus_clk_s_q;
	logic [1:0] sync_ret_s_q;
	logic [1:0] host_mode_s_q;
	logic [1:0] halve_s_q;
	logic [1:0] hard_s_q;
	logic [31:0] rcw_s1_q;
	logic [31:0] rcw_s2_q;
	logic [2:0] settle_q;
	logic host_mode_q;
	logic halve_q;
	scg_pkg::scg_rcw_t rcw_q;
	logic [scg_pkg::NUM_BUS_OUT-1:0] occ_q;
	logic [2*scg_pkg::NUM_UNITS-1:0] unit_modes_q;
	logic [1:0] lbdiv_q;
	logic prim_prev_q;
	logic ref_half_q;
	logic sync_out_q;
	logic [scg_pkg::NUM_BUS_OUT-1:0] bus_out_q;
	logic [1:0] ret_prev_q;
	logic [2:0] ret_edges_q;
	logic locked_q;
	logic csb_phase_q;
	logic mem_clk_q;
	logic mem_clk_n_q;
	logic [1:0] lb_cnt_q;
	logic [1:0] lb_active_q;
	logic lb_clk_q;
	logic [1:0] unit_cnt_q [scg_pkg::NUM_UNITS];
	logic [1:0] unit_mode_q [scg_pkg::NUM_UNITS];
	logic [scg_pkg::NUM_UNITS-1:0] unit_en_q;
	logic [31:0] readdata_q;
	logic waitrequest_q;
	logic primary;
	logic csb_tick;
	logic ddr_tick;
	logic lbiu_tick;
	logic [3:0] pll_mult;
	logic [4:0] ratio;
	scg_pkg::scg_status_t status;

	// Pin inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			host_ref_s_q <= 2'h0;
			bus_clk_s_q <= 2'h0;
			sync_ret_s_q <= 2'h0;
			host_mode_s_q <= 2'h0;
			halve_s_q <= 2'h0;
			hard_s_q <= 2'h0;
			rcw_s1_q <= 32'h0000_0000;
			rcw_s2_q <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			host_ref_s_q <= {host_ref_s_q[0], host_reference_input};
			bus_clk_s_q <= {bus_clk_s_q[0], agent_bus_clock_input};
			sync_ret_s_q <= {sync_ret_s_q[0], sync_return_input};
			host_mode_s_q <= {host_mode_s_q[0], host_mode_strap};
			halve_s_q <= {halve_s_q[0], reference_halve_strap};
			hard_s_q <= {hard_s_q[0], hard_coded_select};
			rcw_s1_q <= reset_config_word_pins;
			rcw_s2_q <= rcw_s1_q;
		end
	end

	// Straps and the reset word are caught once, when both synchroniser stages hold the pins.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			settle_q <= 3'h0;
			host_mode_q <= 1'b0;
			halve_q <= 1'b0;
			rcw_q <= scg_pkg::RCW_RESET;
		end
		else if (clk_en)
		begin
			settle_q <= {settle_q[1:0], 1'b1};
			if (settle_q == 3'h3)
			begin
				host_mode_q <= host_mode_s_q[1];
				halve_q <= halve_s_q[1];
				rcw_q <= hard_s_q[1] ? scg_pkg::RCW_HARD_CODED : rcw_s2_q;
			end
		end
	end
	assign primary = host_mode_q ? host_ref_s_q[1] : bus_clk_s_q[1];
	// Reference divider and sync output selection.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			prim_prev_q <= 1'b0;
			ref_half_q <= 1'b0;
			sync_out_q <= 1'b0;
			bus_out_q <= '0;
		end
		else if (clk_en)
		begin
			prim_prev_q <= primary;
			if (primary && !prim_prev_q)
			begin
				ref_half_q <= !ref_half_q;
			end
			sync_out_q <= halve_q ? ref_half_q : primary;
			bus_out_q <= occ_q & {scg_pkg::NUM_BUS_OUT{halve_q ? ref_half_q : primary}};
		end
	end

	// Sync return edges confirm that the feedback loop is closed.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ret_prev_q <= 2'h0;
			ret_edges_q <= 3'h0;
			locked_q <= 1'b0;
		end
		else if (clk_en)
		begin
			ret_prev_q <= {ret_prev_q[0], sync_ret_s_q[1]};
			if (ret_prev_q[0] && !ret_prev_q[1] && !locked_q)
			begin
				ret_edges_q <= ret_edges_q + 3'h1;
			end
			locked_q <= locked_q || ret_edges_q == scg_pkg::LOCK_EDGES;
		end
	end

	// Multiplier decoding and derived ratios.
	always_comb
	begin
		pll_mult = (rcw_q.system_pll_multiplier < 4'h2) ? 4'h0 : rcw_q.system_pll_multiplier;
		ratio = halve_q ? {pll_mult, 1'b0} : {1'b0, pll_mult};
		status = '0;
		status.sync_locked = locked_q;
		status.host_mode = host_mode_q;
		status.reference_halve = halve_q;
		status.vco_double = rcw_q.memory_clock_mode | rcw_q.local_bus_clock_mode;
		status.mult_reserved = (pll_mult == 4'h0);
		status.vco_divide = scg_pkg::vco_divide_of(rcw_q.oscillator_divider_select);
		status.csb_ratio = ratio;
	end

	// The clock runs at twice the system bus rate; the bus tick is every other cycle.
	assign csb_tick = csb_phase_q;
	assign ddr_tick = rcw_q.memory_clock_mode | csb_tick;
	assign lbiu_tick = rcw_q.local_bus_clock_mode | csb_tick;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			csb_phase_q <= 1'b0;
			mem_clk_q <= 1'b0;
			mem_clk_n_q <= 1'b1;
		end
		else if (clk_en)
		begin
			csb_phase_q <= !csb_phase_q;
			if (ddr_tick)
			begin
				mem_clk_q <= !mem_clk_q;
				mem_clk_n_q <= mem_clk_q;
			end
		end
	end

	// Local bus clock divider; a new ratio takes effect only at a low-phase boundary.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			lb_cnt_q <= 2'h0;
			lb_active_q <= scg_pkg::LBDIV_RESET;
			lb_clk_q <= 1'b0;
		end
		else if (clk_en && lbiu_tick)
		begin
			if (lb_cnt_q == scg_pkg::lb_half_last(lb_active_q))
			begin
				lb_cnt_q <= 2'h0;
				lb_clk_q <= !lb_clk_q;
				if (lb_clk_q)
				begin
					lb_active_q <= lbdiv_q;
				end
			end
			else
			begin
				lb_cnt_q <= lb_cnt_q + 2'h1;
			end
		end
	end

	// Per-unit clock enables; mode changes wait for the end of a whole period.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			unit_en_q <= '0;
			for (int i = 0; i < scg_pkg::NUM_UNITS; i++)
			begin
				unit_cnt_q[i] <= 2'h0;
				unit_mode_q[i] <= scg_pkg::UCM_RESET;
			end
		end
		else if (clk_en)
		begin
			for (int i = 0; i < scg_pkg::NUM_UNITS; i++)
			begin
				unit_en_q[i] <= csb_tick && unit_cnt_q[i] == 2'h0 &&
					unit_mode_q[i] != scg_pkg::UCM_OFF;
				if (csb_tick)
				begin
					if (unit_cnt_q[i] >= scg_pkg::unit_last_count(unit_mode_q[i]))
					begin
						unit_cnt_q[i] <= 2'h0;
						unit_mode_q[i] <= unit_modes_q[2*i +: 2];
					end
					else
					begin
						unit_cnt_q[i] <= unit_cnt_q[i] + 2'h1;
					end
				end
			end
		end
	end

	// Software registers.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			occ_q <= scg_pkg::OCC_RESET;
			unit_modes_q <= {scg_pkg::NUM_UNITS{scg_pkg::UCM_RESET}};
			lbdiv_q <= scg_pkg::LBDIV_RESET;
		end
		else if (clk_en && avs_write && !waitrequest_q)
		begin
			case (avs_address)
				scg_pkg::OFF_OUTPUT_CLOCK_CONTROL:
				begin
					occ_q <= avs_writedata[scg_pkg::NUM_BUS_OUT-1:0];
				end
				scg_pkg::OFF_SYSTEM_CLOCK_CONTROL:
				begin
					unit_modes_q <= avs_writedata[2*scg_pkg::NUM_UNITS-1:0];
				end
				scg_pkg::OFF_LOCAL_BUS_RATIO:
				begin
					lbdiv_q <= avs_writedata[1:0];
				end
				default: ;
			endcase
		end
	end

	// Avalon slave: one wait state, then the answer stands for one cycle.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			waitrequest_q <= 1'b1;
			if ((avs_read || avs_write) && waitrequest_q)
			begin
				waitrequest_q <= 1'b0;
				case (avs_address)
					scg_pkg::OFF_OUTPUT_CLOCK_CONTROL:
						readdata_q <= {{(32-scg_pkg::NUM_BUS_OUT){1'b0}}, occ_q};
					scg_pkg::OFF_SYSTEM_CLOCK_CONTROL:
						readdata_q <= {{(32-2*scg_pkg::NUM_UNITS){1'b0}}, unit_modes_q};
					scg_pkg::OFF_LOCAL_BUS_RATIO:
						readdata_q <= {30'h0000_0000, lbdiv_q};
					scg_pkg::OFF_RESET_CONFIG_WORD_LOW:
						readdata_q <= rcw_q;
					scg_pkg::OFF_CLOCK_STATUS:
						readdata_q <= status;
					default:
						readdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Registered status outputs.
	logic [scg_pkg::CPU_SEL_W-1:0] cpu_sel_q;
	logic [4:0] ratio_q;
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cpu_sel_q <= '0;
			ratio_q <= 5'h00;
		end
		else if (clk_en)
		begin
			cpu_sel_q <= rcw_q.cpu_pll_select;
			ratio_q <= ratio;
		end
	end
	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitrequest_q;
	assign sync_clock_output = sync_out_q;
	assign bus_clock_outputs = bus_out_q;
	assign memory_bus_clock = mem_clk_q;
	assign memory_bus_clock_n = mem_clk_n_q;
	assign local_bus_clock_outputs = {scg_pkg::NUM_LCLK{lb_clk_q}};
	assign unit_clock_enables = unit_en_q;
	assign cpu_pll_select = cpu_sel_q;
	assign csb_ratio = ratio_q;
endmodule // scg_system_clock_generation_unit
`default_nettype wire

// File: scg_board.sv
// Board model: free-running reference oscillators and the sync clock loop-back.
`timescale 1ns/1ps
`default_nettype none
module scg_board
(
	input wire logic clock,
	input wire logic host_mode,
	input wire logic sync_clock_output,
	output logic host_reference_input,
	output logic agent_bus_clock_input,
	output logic sync_return_input
);
	logic [2:0] ref_cnt_q = 3'h0;
	logic [2:0] agt_cnt_q = 3'h0;
	logic ref_q = 1'b0;
	logic agt_q = 1'b0;
	// References run free with periods of 8 and 12 cycles.
	always_ff @(posedge clock)
	begin
		ref_cnt_q <= (ref_cnt_q == 3'h3) ? 3'h0 : ref_cnt_q + 3'h1;
		ref_q <= (ref_cnt_q == 3'h3) ? ~ref_q : ref_q;
		agt_cnt_q <= (agt_cnt_q == 3'h5) ? 3'h0 : agt_cnt_q + 3'h1;
		agt_q <= (agt_cnt_q == 3'h5) ? ~agt_q : agt_q;
	end
	// The host reference is grounded in agent mode.
	assign host_reference_input = host_mode & ref_q;
	assign agent_bus_clock_input = agt_q;
	assign sync_return_input = sync_clock_output;
endmodule // scg_board
`default_nettype wire

// File: scg_assertions.sv
// Port assertions for the system clock generation unit.
`timescale 1ns/1ps
`default_nettype none
module scg_assertions
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [scg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [scg_pkg::NUM_BUS_OUT-1:0] bus_clock_outputs,
	input wire logic memory_bus_clock,
	input wire logic memory_bus_clock_n,
	input wire logic [scg_pkg::NUM_LCLK-1:0] local_bus_clock_outputs,
	input wire logic [scg_pkg::NUM_UNITS-1:0] unit_clock_enables
);
	logic [4:0] occ_q;
	logic [13:0] ucm_q;
	logic [3:0] quiet_q;
	logic [6:0] off;
	logic wr_ok;
	logic wr_u;
	assign wr_ok = avs_write && !avs_waitrequest;
	assign wr_u = wr_ok && avs_address == scg_pkg::OFF_SYSTEM_CLOCK_CONTROL;
	// Mirrors the enable and mode registers and counts cycles since a mode write.
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			occ_q <= scg_pkg::OCC_RESET;
			ucm_q <= 14'h3FFF;
			quiet_q <= 4'h0;
		end
		else
		begin
			if (wr_ok && avs_address == scg_pkg::OFF_OUTPUT_CLOCK_CONTROL)
				occ_q <= avs_writedata[4:0];
			if (wr_u)
				ucm_q <= avs_writedata[13:0];
			quiet_q <= wr_u ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
		end
	end
	always_comb
	begin
		for (int i = 0; i < scg_pkg::NUM_UNITS; i++)
			off[i] = ucm_q[2*i +: 2] == scg_pkg::UCM_OFF;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ans; ##[1:2] !avs_waitrequest; endsequence
	property p_answer; s_req |-> s_ans; endproperty
	property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address > 5'h10 |-> avs_readdata == 32'h0;
	endproperty
	property p_bus_gate; (bus_clock_outputs & ~occ_q & ~$past(occ_q)) == 5'h0; endproperty
	property p_mem_pair; memory_bus_clock_n == !memory_bus_clock; endproperty
	property p_lb_same; (&local_bus_clock_outputs) || !(|local_bus_clock_outputs); endproperty
	property p_unit_off; quiet_q == 4'hF |-> (unit_clock_enables & off) == 7'h0; endproperty
	property p_unit_gap; (unit_clock_enables & $past(unit_clock_enables)) == 7'h0; endproperty
	a_answer: assert property (p_answer) else $error("Request not answered in time.");
	a_wait_one: assert property (p_wait_one) else $error("Answer lasted over one cycle.");
	a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");
	a_bus_gate: assert property (p_bus_gate) else $error("Disabled bus clock ran.");
	a_mem_pair: assert property (p_mem_pair) else $error("Memory clock pair broken.");
	a_lb_same: assert property (p_lb_same) else $error("Local clocks differ.");
	a_unit_off: assert property (p_unit_off) else $error("Stopped unit pulsed.");
	a_unit_gap: assert property (p_unit_gap) else $error("Unit pulse too long.");
endmodule // scg_assertions
bind scg_system_clock_generation_unit scg_assertions chk
(
	.clock(clock),
	.sys_rst(sys_rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.bus_clock_outputs(bus_clock_outputs),
	.memory_bus_clock(memory_bus_clock),
	.memory_bus_clock_n(memory_bus_clock_n),
	.local_bus_clock_outputs(local_bus_clock_outputs),
	.unit_clock_enables(unit_clock_enables)
);
`default_nettype wire

// File: scg_system_clock_generation_unit_bench.sv
// Self-checking bench for the system clock generation unit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) \
	begin \
		check_count++; \
		if ((a) !== (e)) \
		begin \
			failures++; \
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, a); \
		end \
	end
module scg_system_clock_generation_unit_bench;
	typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] e; int s; int p;} scg_row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic hm = 1'b1;
	logic hv = 1'b0;
	logic hc = 1'b0;
	logic [31:0] pins = 32'h0;
	logic [4:0] addr = 5'h0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic wait_n;
	logic sync_out, ref_in, agt_in, ret_in, mem_clk, mem_clk_n;
	logic [4:0] bus_out;
	logic [4:0] csb;
	logic [2:0] lb_clk;
	logic [6:0] uen;
	logic [6:0] cpu;
	logic [31:0] rd;
	int failures = 0;
	int check_count = 0;
	int p;
	scg_pkg::scg_status_t st;
	scg_row_t rows [11] = '{'{5'h00, 32'h0A, 32'h0A, 4, 8}, '{5'h00, 32'h15, 32'h15, 4, 0},
		'{5'h04, 32'h1555, 32'h1555, 1, 2}, '{5'h04, 32'h2AAA, 32'h2AAA, 1, 4},
		'{5'h04, 32'h3FFF, 32'h3FFF, 1, 6}, '{5'h04, 32'h0, 32'h0, 1, 0},
		'{5'h08, 32'h0, 32'h0, 2, 4}, '{5'h08, 32'h1, 32'h1, 2, 8},
		'{5'h08, 32'h2, 32'h2, 2, 16}, '{5'h0C, 32'hFFFF_FFFF, 32'h1523_0000, 5, 4},
		'{5'h14, 32'h5, 32'h0, 5, 4}};
	always #4 clock = ~clock;
	scg_board board
	(
		.clock(clock),
		.host_mode(hm),
		.sync_clock_output(sync_out),
		.host_reference_input(ref_in),
		.agent_bus_clock_input(agt_in),
		.sync_return_input(ret_in)
	);
	scg_system_clock_generation_unit dut
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(1'b1),
		.host_mode_strap(hm),
		.host_reference_input(ref_in),
		.agent_bus_clock_input(agt_in),
		.reference_halve_strap(hv),
		.sync_return_input(ret_in),
		.hard_coded_select(hc),
		.reset_config_word_pins(pins),
		.avs_address(addr),
		.avs_read(rd_en),
		.avs_write(wr_en),
		.avs_writedata(wd),
		.avs_readdata(rdata),
		.avs_waitrequest(wait_n),
		.sync_clock_output(sync_out),
		.bus_clock_outputs(bus_out),
		.memory_bus_clock(mem_clk),
		.memory_bus_clock_n(mem_clk_n),
		.local_bus_clock_outputs(lb_clk),
		.unit_clock_enables(uen),
		.cpu_pll_select(cpu),
		.csb_ratio(csb)
	);
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wr_en <= w;
		rd_en <= !w;
		wd <= d;
		do
			@(posedge clock);
		while (wait_n !== 1'b0);
		rd = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	function automatic logic pick(int s);
		case (s)
			1: pick = uen[0];
			2: pick = lb_clk[0];
			3: pick = sync_out;
			4: pick = bus_out[1];
			default: pick = mem_clk;
		endcase
	endfunction
	// Returns the settled period of a signal in cycles, or 0 if it does not run.
	task automatic period(input int s, output int q);
		int t;
		for (int k = 0; k < 3; k++)
		begin
			t = 0;
			while (pick(s) !== 1'b0 && t < 40) @(posedge clock) t++;
			while (pick(s) !== 1'b1 && t < 40) @(posedge clock) t++;
			q = (t < 40) ? t : 0;
		end
	endtask
	task automatic restart(input logic m, input logic v, input logic h, input logic [31:0] w);
		hm <= m;
		hv <= v;
		hc <= h;
		pins <= w;
		sys_rst <= 1'b1;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (80) @(posedge clock);
	endtask
	initial
	begin
		#100000;
		failures++;
		conclude();
	end
	initial
	begin
		restart(1'b1, 1'b0, 1'b0, 32'h1523_0000);
		`CHK("csb ratio", 5'h05, csb)
		`CHK("cpu select", 7'h23, cpu)
		bus(1'b0, 5'h0C, 32'h0);
		`CHK("reset word", 32'h1523_0000, rd)
		st = '{18'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 5'h05};
		bus(1'b0, 5'h10, 32'h0);
		`CHK("status", 32'(st), rd)
		for (int i = 0; i < 11; i++)
		begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			`CHK("readback", rows[i].e, rd)
			period(rows[i].s, p);
			`CHK("period", rows[i].p, p)
		end
		restart(1'b0, 1'b0, 1'b0, 32'hC110_0000);
		bus(1'b0, 5'h00, 32'h0);
		`CHK("occ reset", 32'h1F, rd)
		bus(1'b0, 5'h04, 32'h0);
		`CHK("mode reset", 32'h3FFF, rd)
		bus(1'b0, 5'h08, 32'h0);
		`CHK("divider reset", 32'h2, rd)
		`CHK("reserved ratio", 5'h00, csb)
		st = '{18'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h4, 5'h00};
		bus(1'b0, 5'h10, 32'h0);
		`CHK("status", 32'(st), rd)
		period(3, p);
		`CHK("agent sync", 12, p)
		period(1, p);
		`CHK("unit default", 6, p)
		period(2, p);
		`CHK("fast local", 8, p)
		period(5, p);
		`CHK("fast memory", 2, p)
		restart(1'b1, 1'b1, 1'b1, 32'hFFFF_FFFF);
		bus(1'b0, 5'h0C, 32'h0);
		`CHK("hard word", scg_pkg::RCW_HARD_CODED, rd)
		`CHK("halved ratio", 5'h08, csb)
		`CHK("hard cpu", 7'h02, cpu)
		period(3, p);
		`CHK("halved sync", 16, p)
		conclude();
	end
endmodule // scg_system_clock_generation_unit_bench
`default_nettype wire
